// [logic/asr_regs.vh]
/*
  Constants for the asynchronous serial receiver: register offsets, bit positions,
  reset values and oversample phase numbers.
  Assumes it is included by bare name from the design files under logic/.
*/
// Functional notes
// - Characters are 8 or 9 data bits.
// - Ninth bit holds bit 8, or bit 7.
// - Data buffer is read-only behind the bus.
// - Full character loads buffer, sets full flag.
// - Full flag and enable raise interrupt request.
// - Line sampled at sixteen times baud.
// - Resync after start and one-to-zero data change.
// - Start is zero after three ones.
// - Start verified at phases 3, 5, 7.
// - Two ones among those restart search quietly.
// - Data bit is majority of 8-10; disagreement flags noise.
// - Ones at start phases 8-10 flag noise only.
// - Stop majority zero is framing; disagreement noise.
// - Break sets framing error as well.
// - Framing error set with the full flag.
// - Resync on each valid falling edge in character; the code ignores edges at phases 8-10.
// - All-zero character with zero stop is break.
// - Unread buffer: overrun set, new character dropped.
`ifndef ASR_REGS_VH
`define ASR_REGS_VH

// Register offsets.
`define ASR_OFS_CTRL1 3'h0
`define ASR_OFS_CTRL2 3'h1
`define ASR_OFS_STAT1 3'h2
`define ASR_OFS_STAT2 3'h3
`define ASR_OFS_DATA 3'h4
`define ASR_OFS_BAUD 3'h5

// Control register one bits.
`define ASR_C1_ENABLE 1
`define ASR_C1_NINE 0
// Control register two bits.
`define ASR_C2_RXEN 1
`define ASR_C2_IRQEN 0
// Status register one bits.
`define ASR_S1_FULL 3
`define ASR_S1_OVR 2
`define ASR_S1_NOISE 1
`define ASR_S1_FRAME 0
// Status register two bits.
`define ASR_S2_BREAK 1
`define ASR_S2_BUSY 0

// Reset values.
`define ASR_RST_CTRL 8'h00
`define ASR_RST_BAUD 8'h00
`define ASR_ZERO8 8'h00
`define ASR_ZERO9 9'h000

// Oversample phase numbers within a bit.
`define ASR_PH_LAST 4'hF
`define ASR_PH_S3 4'h2
`define ASR_PH_S5 4'h4
`define ASR_PH_S7 4'h6
`define ASR_PH_S8 4'h7
`define ASR_PH_S9 4'h8
`define ASR_PH_S10 4'h9
`define ASR_PH_EDGE 4'h1

// Stop bit index per frame (start + data bit count).
`define ASR_STOP_IDX8 4'h9
`define ASR_STOP_IDX9 4'hA

`endif

// [logic/asr_tick.v]
/*
  Oversample tick divider: pulses once per oversample period.
  Assumes mclk 100 MHz; the divide value comes from the baud register.
*/
`timescale 1ns/1ps
module asr_tick (
  // Clock and reset.
  input wire mclk,
  input wire rst_n,
  // Control.
  input wire run,
  input wire [7:0] divide,
  // Tick out.
  output reg tick
);

  reg [7:0] count;

  // Counts down from the divide value; one tick per wrap.
  always @(posedge mclk) begin
    if (!rst_n || !run) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else if (count == 8'h00) begin
      count <= divide;
      tick <= 1'b1;
    end else begin
      count <= count - 8'h01;
      tick <= 1'b0;
    end
  end

endmodule

// [logic/asr_rx.v]
/*
  Receive half of an asynchronous NRZ serial port with 16x oversampling,
  majority voting, noise and framing detection and a read-only data buffer.
  Assumes the receive pin is asynchronous to mclk and a simple strobe register port.
*/
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "asr_regs.vh"
module asr_rx (
  // Clock and reset.
  input wire mclk,
  input wire rst_n,
  // Register port.
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // Serial line.
  input wire rxd,
  // Interrupt request.
  output reg rx_irq
);

  localparam ST_IDLE = 2'b00;
  localparam ST_START = 2'b01;
  localparam ST_DATA = 2'b10;

  reg [7:0] control_reg_one;
  reg [7:0] control_reg_two;
  reg [7:0] baud;
  reg [7:0] receive_data_buffer;
  reg ninth_bit;
  reg receiver_full_flag;
  reg overrun_flag;
  reg noise_flag;
  reg framing_error_flag;
  reg break_flag;
  reg status_armed;
  reg [1:0] state;
  reg [3:0] oversample_clock;
  reg [3:0] bit_idx;
  reg [8:0] shift;
  reg [2:0] votes;
  reg [2:0] hist;
  reg prev_bit;
  reg pend_noise;
  reg sync1;
  reg sync2;
  reg sync3;
  reg line;
  wire tick;
  wire enabled;
  wire nine;
  wire [3:0] stop_idx;
  wire vote;
  wire disagree;

  // Majority of three samples.
  function maj3;
    input [2:0] s;
    begin
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    end
  endfunction

  assign enabled = control_reg_one[`ASR_C1_ENABLE] & control_reg_two[`ASR_C2_RXEN];
  assign nine = control_reg_one[`ASR_C1_NINE];
  assign stop_idx = nine ? `ASR_STOP_IDX9 : `ASR_STOP_IDX8;
  assign vote = maj3({votes[2:1], line});
  assign disagree = ({votes[2:1], line} != 3'b000) && ({votes[2:1], line} != 3'b111);

  asr_tick u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(enabled),
    .divide(baud),
    .tick(tick)
  );

  // Three-stage pin synchroniser; a change counts once stages two and three agree.
  always @(posedge mclk) begin
    if (!rst_n) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      line <= 1'b1;
    end else begin
      sync1 <= rxd;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        line <= sync3;
      end
    end
  end

  // Register writes; the status-then-data sequence that clears the full flag runs in the receive engine.
  always @(posedge mclk) begin
    if (!rst_n) begin
      control_reg_one <= `ASR_RST_CTRL;
      control_reg_two <= `ASR_RST_CTRL;
      baud <= `ASR_RST_BAUD;
    end else if (wr) begin
      case (addr)
        `ASR_OFS_CTRL1: control_reg_one <= wdata;
        `ASR_OFS_CTRL2: control_reg_two <= wdata;
        `ASR_OFS_BAUD: baud <= wdata;
        default: ; // Data buffer is read-only; writes are ignored.
      endcase
    end
  end

  // Read data, presented in the cycle after the read strobe.
  always @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= `ASR_ZERO8;
    end else if (rd) begin
      case (addr)
        `ASR_OFS_CTRL1: rdata <= control_reg_one;
        `ASR_OFS_CTRL2: rdata <= control_reg_two;
        `ASR_OFS_BAUD: rdata <= baud;
        `ASR_OFS_STAT1: rdata <= {4'h0, receiver_full_flag, overrun_flag, noise_flag, framing_error_flag};
        `ASR_OFS_STAT2: rdata <= {5'h00, ninth_bit, break_flag, (state != ST_IDLE)};
        `ASR_OFS_DATA: rdata <= receive_data_buffer;
        default: rdata <= `ASR_ZERO8;
      endcase
    end else begin
      rdata <= `ASR_ZERO8;
    end
  end

  // Interrupt request follows the full flag gated by its enable.
  always @(posedge mclk) begin
    if (!rst_n) begin
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= receiver_full_flag & control_reg_two[`ASR_C2_IRQEN];
    end
  end

  // Receive engine: start search, verification, bit recovery and character delivery.
  always @(posedge mclk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      oversample_clock <= 4'h0;
      bit_idx <= 4'h0;
      shift <= `ASR_ZERO9;
      votes <= 3'b000;
      hist <= 3'b000;
      prev_bit <= 1'b1;
      pend_noise <= 1'b0;
      receive_data_buffer <= `ASR_ZERO8;
      ninth_bit <= 1'b0;
      receiver_full_flag <= 1'b0;
      overrun_flag <= 1'b0;
      noise_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      break_flag <= 1'b0;
      status_armed <= 1'b0;
    end else begin
      // Reading status while full arms the clear; reading data then clears status.
      if (rd && addr == `ASR_OFS_STAT1 && receiver_full_flag) begin
        status_armed <= 1'b1;
      end
      if (rd && addr == `ASR_OFS_DATA && status_armed) begin
        status_armed <= 1'b0;
        receiver_full_flag <= 1'b0;
        overrun_flag <= 1'b0;
        noise_flag <= 1'b0;
        framing_error_flag <= 1'b0;
        break_flag <= 1'b0;
      end
      if (!enabled) begin
        state <= ST_IDLE;
        hist <= 3'b000;
      end else if (tick) begin
        case (state)
          ST_IDLE: begin
            hist <= {hist[1:0], line};
            if (hist == 3'b111 && !line) begin
              state <= ST_START;
              oversample_clock <= `ASR_PH_EDGE;
              pend_noise <= 1'b0;
            end
          end
          ST_START: begin
            oversample_clock <= oversample_clock + 4'h1;
            if (oversample_clock == `ASR_PH_S3) votes[2] <= line;
            if (oversample_clock == `ASR_PH_S5) votes[1] <= line;
            if (oversample_clock == `ASR_PH_S7) begin
              if (maj3({votes[2:1], line})) begin
                state <= ST_IDLE;
                hist <= 3'b000;
                oversample_clock <= 4'h0;
              end else if (disagree) begin
                pend_noise <= 1'b1;
              end
            end
            if (oversample_clock == `ASR_PH_S8) votes[2] <= line;
            if (oversample_clock == `ASR_PH_S9) votes[1] <= line;
            if (oversample_clock == `ASR_PH_S10 && {votes[2:1], line} != 3'b000) begin
              pend_noise <= 1'b1;
            end
            if (oversample_clock == `ASR_PH_LAST) begin
              state <= ST_DATA;
              bit_idx <= 4'h1;
              prev_bit <= 1'b0;
            end
          end
          ST_DATA: begin
            oversample_clock <= oversample_clock + 4'h1;
            // The line history also runs here, so a falling edge is a real 1-to-0 step.
            hist <= {hist[1:0], line};
            // A falling edge after a bit voted 1 realigns the phase to that edge.
            // Inside the voting window the phase is left alone, so a late edge cannot swallow a bit.
            if (prev_bit && hist[0] && !line &&
                (oversample_clock < `ASR_PH_S8 || oversample_clock > `ASR_PH_S10)) begin
              oversample_clock <= `ASR_PH_EDGE;
            end
            if (oversample_clock == `ASR_PH_S8) votes[2] <= line;
            if (oversample_clock == `ASR_PH_S9) votes[1] <= line;
            if (oversample_clock == `ASR_PH_S10) begin
              prev_bit <= vote;
              if (disagree) pend_noise <= 1'b1;
              if (bit_idx != stop_idx) begin
                shift <= {vote, shift[8:1]};
                bit_idx <= bit_idx + 4'h1;
              end else begin
                // The stop samples stay in the history, so a zero stop cannot pose as a new start.
                state <= ST_IDLE;
                if (receiver_full_flag) begin
                  overrun_flag <= 1'b1;
                end else begin
                  // Data moves to the buffer with the full flag.
                  receiver_full_flag <= 1'b1;
                  framing_error_flag <= ~vote;
                  noise_flag <= pend_noise | disagree;
                  if (nine) begin
                    receive_data_buffer <= shift[7:0];
                    ninth_bit <= shift[8];
                  end else begin
                    receive_data_buffer <= shift[8:1];
                    ninth_bit <= shift[8];
                  end
                  if (!vote && shift[8:1] == `ASR_ZERO8 && (!nine || !shift[0])) begin
                    break_flag <= 1'b1;
                    ninth_bit <= 1'b0;
                  end
                end
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

// [sim/asr_rx_sva.sv]
/*
  Checker for asr_rx: read timing, read-only buffer and interrupt gating.
  Assumes one clock domain with a synchronous active-low reset.
*/
`timescale 1ns/1ps
module asr_rx_sva (
  // Clock and reset.
  input wire mclk,
  input wire rst_n,
  // Register port.
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  // Line and interrupt.
  input wire rxd,
  input wire rx_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  reg ien;
  reg [2:0] quiet;
  // Mirrors the interrupt enable and counts cycles since the last strobe.
  always @(posedge mclk) begin
    if (!rst_n) begin
      ien <= 1'b0;
      quiet <= 3'h7;
    end else begin
      if (wr && addr == 3'h1)
        ien <= wdata[0];
      quiet <= (wr || rd) ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
    end
  end
  // Bus steps used by the multi-cycle properties.
  sequence rd_data; rd && addr == 3'h4; endsequence
  sequence wr_data; wr && addr == 3'h4; endsequence
  sequence wr_ctl; wr && addr == 3'h0; endsequence
  sequence rd_ctl; rd && addr == 3'h0; endsequence
  rdata_quiet_a: assert property (!rd |=> rdata == 8'h00) else $error("rdata without read");
  unmapped_zero_a: assert property (rd && addr > 3'h5 |=> rdata == 8'h00) else $error("unmapped read");
  ctrl_readback_a: assert property (wr_ctl ##1 rd_ctl |=> rdata[1:0] == $past(wdata[1:0], 2))
    else $error("ctrl readback");
  buffer_ro_a: assert property (rd_data ##1 wr_data ##1 rd_data |=> rdata == $past(rdata, 2))
    else $error("buffer written");
  irq_gate_a: assert property (rx_irq |-> $past(ien)) else $error("irq while disabled");
  irq_off_a: assert property (wr && addr == 3'h1 && !wdata[0] |-> ##2 !rx_irq) else $error("irq stays");
  irq_fall_a: assert property ($fell(rx_irq) |-> quiet < 3'h4) else $error("irq fell alone");
  stat_irq_a: assert property (rd && addr == 3'h2 && ien |=> rdata[3] == rx_irq) else $error("full vs irq");
endmodule
bind asr_rx asr_rx_sva chk (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .rxd(rxd), .rx_irq(rx_irq));

// [sim/asr_line_tx.sv]
/*
  Remote transmitter model driving the receive line.
  Assumes bit times given in mclk cycles; the line idles high.
*/
`timescale 1ns/1ps
module asr_line_tx (
  // Clock.
  input wire mclk,
  // Line out.
  output reg rxd
);
  initial rxd = 1'b1;
  // Sends n bits LSB first, per cycles each, then two idle bits.
  // Cycles fl and fl+1 are inverted as noise; a one-cycle spike would not pass the pin filter.
  // A negative fl sends a clean frame.
  task send(input [10:0] f, input integer n, input integer per, input integer fl);
    integer i;
    begin
      for (i = 0; i < (n + 2) * per; i = i + 1) begin
        @(posedge mclk);
        rxd <= ((i < n * per) ? f[i / per] : 1'b1) ^ (fl >= 0 && (i == fl || i == fl + 1));
      end
    end
  endtask
endmodule

// [sim/tb_top.sv]
/*
  Testbench for asr_rx: frames from the line model, checks over the register port.
  Assumes 100 MHz mclk and baud divider 0, so one bit lasts 16 mclk; the slow scenario uses divider 1.
*/
`timescale 1ns/1ps
module tb_top;
  reg mclk, rst_n, wr, rd;
  reg [2:0] addr;
  reg [7:0] wdata, q;
  wire [7:0] rdata;
  wire rxd, rx_irq;
  integer n_fail, tests_run;
  asr_rx DUT (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rxd(rxd), .rx_irq(rx_irq));
  asr_line_tx line (.mclk(mclk), .rxd(rxd));
  // Free-running clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task test_done;
    begin
      if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [8*5:1] n, input [7:0] e, input [7:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("BAD %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  // Drives one bus cycle and captures the answer to the previous cycle.
  task bus(input w, input r, input [2:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      #1 q = rdata;
    end
  endtask
  task rdc(input [2:0] a, input [7:0] m, input [7:0] e);
    begin
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, 3'h0, 8'h00);
      chk({"reg", 8'h30 + {5'h00, a}}, e, q & m);
    end
  endtask
  task setup(input [7:0] c1, input [7:0] c2);
    begin
      bus(1'b1, 1'b0, 3'h5, 8'h00);
      bus(1'b1, 1'b0, 3'h1, c2);
      bus(1'b1, 1'b0, 3'h0, c1);
      bus(1'b0, 1'b1, 3'h0, 8'h00);
      bus(1'b0, 1'b0, 3'h0, 8'h00);
      chk("ctrl1", c1 & 8'h03, q & 8'h03);
    end
  endtask
  // Reads status two, status one, data, then confirms the flags cleared.
  task got(input [7:0] s1, input [7:0] s2, input [7:0] d);
    begin
      rdc(3'h3, 8'h07, s2);
      rdc(3'h2, 8'h0F, s1);
      rdc(3'h4, 8'hFF, d);
      rdc(3'h2, 8'h0F, 8'h00);
    end
  endtask
  task t_eight;
    begin
      setup(8'h02, 8'h02);
      line.send({2'b11, 8'hA5, 1'b0}, 10, 16, -1);
      got(8'h08, 8'h04, 8'hA5);
      rdc(3'h6, 8'hFF, 8'h00);
    end
  endtask
  task t_nine;
    begin
      setup(8'h03, 8'h02);
      line.send({1'b1, 9'h0DA, 1'b0}, 11, 16, -1);
      got(8'h08, 8'h00, 8'hDA);
    end
  endtask
  task t_frame;
    begin
      setup(8'h02, 8'h02);
      line.send({2'b10, 8'h3C, 1'b0}, 10, 16, -1);
      got(8'h09, 8'h00, 8'h3C);
      line.send({2'b10, 8'h00, 1'b0}, 10, 16, -1);
      got(8'h09, 8'h02, 8'h00);
    end
  endtask
  task t_noise;
    begin
      line.send({2'b11, 8'hA5, 1'b0}, 10, 16, 8);
      got(8'h0A, 8'h04, 8'hA5);
      line.send({2'b11, 8'hA5, 1'b0}, 10, 16, 25);
      got(8'h0A, 8'h04, 8'hA5);
    end
  endtask
  task t_over;
    begin
      line.send({2'b11, 8'h11, 1'b0}, 10, 16, -1);
      line.send({2'b11, 8'h22, 1'b0}, 10, 16, -1);
      got(8'h0C, 8'h00, 8'h11);
    end
  endtask
  task t_glitch;
    begin
      line.send(11'h000, 0, 16, 0);
      rdc(3'h2, 8'h0F, 8'h00);
      line.send({2'b11, 8'h81, 1'b0}, 10, 16, -1);
      got(8'h08, 8'h04, 8'h81);
      line.send({2'b11, 8'h55, 1'b0}, 10, 15, -1);
      got(8'h08, 8'h00, 8'h55);
    end
  endtask
  // Divider 1 doubles the bit time to 32 mclk; 16 samples per bit still land mid-bit.
  task t_slow;
    begin
      bus(1'b1, 1'b0, 3'h5, 8'h01);
      bus(1'b0, 1'b0, 3'h0, 8'h00);
      line.send({2'b11, 8'h5A, 1'b0}, 10, 32, -1);
      got(8'h08, 8'h00, 8'h5A);
    end
  endtask
  task t_irq;
    begin
      setup(8'h02, 8'h03);
      line.send({2'b11, 8'h7E, 1'b0}, 10, 16, -1);
      chk("irq", 8'h01, {7'h00, rx_irq});
      bus(1'b1, 1'b0, 3'h1, 8'h02);
      bus(1'b0, 1'b0, 3'h0, 8'h00);
      bus(1'b0, 1'b0, 3'h0, 8'h00);
      chk("irq", 8'h00, {7'h00, rx_irq});
      setup(8'h02, 8'h03);
      chk("irq", 8'h01, {7'h00, rx_irq});
      bus(1'b0, 1'b1, 3'h2, 8'h00);
      bus(1'b0, 1'b1, 3'h4, 8'h00);
      bus(1'b1, 1'b0, 3'h4, 8'hFF);
      bus(1'b0, 1'b1, 3'h4, 8'h00);
      bus(1'b0, 1'b0, 3'h0, 8'h00);
      chk("data", 8'h7E, q);
      chk("irq", 8'h00, {7'h00, rx_irq});
    end
  endtask
  // Main sequence after a 16-cycle reset.
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    q = 8'h00;
    n_fail = 0;
    tests_run = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_eight;
    t_nine;
    t_frame;
    t_noise;
    t_over;
    t_glitch;
    t_slow;
    t_irq;
    test_done;
  end
  // Cuts a hang short.
  initial begin
    repeat (100000) @(posedge mclk);
    n_fail = n_fail + 1;
    test_done;
  end
endmodule
